// ---- core/spic_ctrl_status.sv ----
// SPI control and status register with event flags and select pin control
`timescale 1ns/1ps
module spic_ctrl_status
  import spic_pkg::*;
(
  input  wire logic       i_sys_clk,       // System clock, 200 MHz
  input  wire logic       i_rst_b,         // Synchronous reset, active low
  input  wire logic [7:0] i_sfr_addr,      // Register address
  input  wire logic       i_sfr_wr,        // Register write strobe
  input  wire logic       i_sfr_rd,        // Register read strobe
  input  wire logic [7:0] i_sfr_wdata,     // Register write data
  output logic      [7:0] o_sfr_rdata,     // Register read data
  input  wire logic       i_data_reg_wr,   // Write to SPI data register
  input  wire logic       i_rx_buf_full,   // Receive buffer holds unread data
  input  wire logic       i_master_en,     // Master enable bit
  input  wire logic       i_link_clk,      // Shift engine clock
  input  wire logic       i_lk_xfer_done,  // Pulse, transfer finished
  input  wire logic       i_lk_shift_load, // Pulse, buffer moved to shift register
  input  wire logic       i_lk_last_bit,   // Pulse, last bit shifted in
  input  wire logic       i_lk_busy,       // Level, transfer in progress
  input  wire logic       i_ss_in,         // Slave select pin level
  output logic            o_ss_out,        // Slave select pin drive value
  output logic            o_ss_oe_b,       // Slave select drive enable, low drives
  output logic            o_spi_irq,       // SPI interrupt request
  output logic            o_port_en,       // Port enable
  output logic      [1:0] o_select_mode,   // Select mode field
  output logic            o_tx_empty,      // Transmit buffer empty
  output logic            o_ss_used        // Select pin routed to a port pin
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic tgl_edge(input logic cur, input logic prev);
    tgl_edge = cur ^ prev;
  endfunction

  function automatic logic csr_hit(input logic strobe, input logic [7:0] addr);
    csr_hit = strobe && (addr == SPIC_CSR_ADDR);
  endfunction

  // ****************************************************************
  // Link event capture
  // ****************************************************************
  spic_evt_if evt ();

  spic_link_evt u_link_evt (
    .i_link_clk      (i_link_clk),
    .i_rst_b         (i_rst_b),
    .i_lk_xfer_done  (i_lk_xfer_done),
    .i_lk_shift_load (i_lk_shift_load),
    .i_lk_last_bit   (i_lk_last_bit),
    .i_lk_busy       (i_lk_busy),
    .evt             (evt.link)
  );

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic done_meta_r;
  logic done_sync_r;
  logic done_prev_r;
  logic load_meta_r;
  logic load_sync_r;
  logic load_prev_r;
  logic last_meta_r;
  logic last_sync_r;
  logic last_prev_r;
  logic busy_meta_r;
  logic busy_sync_r;
  logic ss_meta_r;
  logic ss_sync_r;
  logic done_meta_nxt;
  logic done_sync_nxt;
  logic done_prev_nxt;
  logic load_meta_nxt;
  logic load_sync_nxt;
  logic load_prev_nxt;
  logic last_meta_nxt;
  logic last_sync_nxt;
  logic last_prev_nxt;
  logic busy_meta_nxt;
  logic busy_sync_nxt;
  logic ss_meta_nxt;
  logic ss_sync_nxt;

  always_comb begin
    done_meta_nxt = evt.done_tgl;
    done_sync_nxt = done_meta_r;
    done_prev_nxt = done_sync_r;
    load_meta_nxt = evt.load_tgl;
    load_sync_nxt = load_meta_r;
    load_prev_nxt = load_sync_r;
    last_meta_nxt = evt.last_tgl;
    last_sync_nxt = last_meta_r;
    last_prev_nxt = last_sync_r;
    busy_meta_nxt = evt.busy;
    busy_sync_nxt = busy_meta_r;
    ss_meta_nxt   = i_ss_in;
    ss_sync_nxt   = ss_meta_r;
    if (!i_rst_b) begin
      done_meta_nxt = SPIC_SYNC_RESET;
      done_sync_nxt = SPIC_SYNC_RESET;
      done_prev_nxt = SPIC_SYNC_RESET;
      load_meta_nxt = SPIC_SYNC_RESET;
      load_sync_nxt = SPIC_SYNC_RESET;
      load_prev_nxt = SPIC_SYNC_RESET;
      last_meta_nxt = SPIC_SYNC_RESET;
      last_sync_nxt = SPIC_SYNC_RESET;
      last_prev_nxt = SPIC_SYNC_RESET;
      busy_meta_nxt = SPIC_SYNC_RESET;
      busy_sync_nxt = SPIC_SYNC_RESET;
      ss_meta_nxt   = SPIC_NSS_SYNC_RESET;
      ss_sync_nxt   = SPIC_NSS_SYNC_RESET;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    done_meta_r <= done_meta_nxt;
    done_sync_r <= done_sync_nxt;
    done_prev_r <= done_prev_nxt;
    load_meta_r <= load_meta_nxt;
    load_sync_r <= load_sync_nxt;
    load_prev_r <= load_prev_nxt;
    last_meta_r <= last_meta_nxt;
    last_sync_r <= last_sync_nxt;
    last_prev_r <= last_prev_nxt;
    busy_meta_r <= busy_meta_nxt;
    busy_sync_r <= busy_sync_nxt;
    ss_meta_r   <= ss_meta_nxt;
    ss_sync_r   <= ss_sync_nxt;
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************
  logic [7:0] csr_r;
  logic       ev_done;
  logic       ev_load;
  logic       ev_last;
  logic       ev_write_collision_flag;
  logic       ev_mode_fault_flag;
  logic       ev_ovr;
  logic       csr_hit_wr;
  logic       csr_hit_rd;
  spic_mode_t mode_cur;

  always_comb begin
    mode_cur   = spic_mode_t'(csr_r[SPIC_MODE_HI:SPIC_MODE_LO]);
    ev_done    = tgl_edge(done_sync_r, done_prev_r);
    ev_load    = tgl_edge(load_sync_r, load_prev_r);
    ev_last    = tgl_edge(last_sync_r, last_prev_r);
    ev_write_collision_flag    = i_data_reg_wr && busy_sync_r;                          // [RL3]
    ev_mode_fault_flag    = !ss_sync_r && i_master_en && (mode_cur == SPIC_MODE_MULTI); // [RL4]
    ev_ovr     = ev_last && i_rx_buf_full && !i_master_en;              // [RL5]
    csr_hit_wr = csr_hit(i_sfr_wr, i_sfr_addr);
    csr_hit_rd = csr_hit(i_sfr_rd, i_sfr_addr);
  end

  // ****************************************************************
  // Control and status register
  // ****************************************************************
  logic [7:0] csr_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic       ss_out_r;
  logic       ss_out_nxt;
  logic       ss_oe_b_r;
  logic       ss_oe_b_nxt;
  logic       ss_used_r;
  logic       ss_used_nxt;

  always_comb begin
    csr_nxt = csr_r;
    if (csr_hit_wr) begin
      csr_nxt[SPIC_DONE_BIT]             = i_sfr_wdata[SPIC_DONE_BIT];  // [RL1]
      csr_nxt[SPIC_WRITE_COLLISION_FLAG_BIT]             = i_sfr_wdata[SPIC_WRITE_COLLISION_FLAG_BIT];
      csr_nxt[SPIC_MODE_FAULT_FLAG_BIT]             = i_sfr_wdata[SPIC_MODE_FAULT_FLAG_BIT];
      csr_nxt[SPIC_OVR_BIT]              = i_sfr_wdata[SPIC_OVR_BIT];
      csr_nxt[SPIC_MODE_HI:SPIC_MODE_LO] = i_sfr_wdata[SPIC_MODE_HI:SPIC_MODE_LO];
      csr_nxt[SPIC_EN_BIT]               = i_sfr_wdata[SPIC_EN_BIT];
    end
    // Hardware sets win over a clearing write
    if (ev_done) begin
      csr_nxt[SPIC_DONE_BIT] = 1'b1;                                    // [RL1]
    end
    if (ev_write_collision_flag) begin
      csr_nxt[SPIC_WRITE_COLLISION_FLAG_BIT] = 1'b1;                                    // [RL3]
    end
    if (ev_mode_fault_flag) begin
      csr_nxt[SPIC_MODE_FAULT_FLAG_BIT] = 1'b1;                                    // [RL4]
    end
    if (ev_ovr) begin
      csr_nxt[SPIC_OVR_BIT] = 1'b1;                                     // [RL5]
    end
    // New data in the buffer outranks a load in the same cycle
    if (ev_load) begin
      csr_nxt[SPIC_TRANSMIT_BUFFER_EMPTY_BIT] = 1'b1;                                   // [RL7]
    end
    if (i_data_reg_wr) begin
      csr_nxt[SPIC_TRANSMIT_BUFFER_EMPTY_BIT] = 1'b0;                                   // [RL7]
    end
    if (!i_rst_b) begin
      csr_nxt = SPIC_CSR_RESET;
    end
  end

  always_comb begin
    rdata_nxt = SPIC_RDATA_IDLE;
    if (csr_hit_rd) begin
      rdata_nxt = csr_r;
    end
    irq_nxt = csr_nxt[SPIC_DONE_BIT] | csr_nxt[SPIC_WRITE_COLLISION_FLAG_BIT]          // [RL2] [RL8]
            | csr_nxt[SPIC_MODE_FAULT_FLAG_BIT] | csr_nxt[SPIC_OVR_BIT];
    ss_used_nxt = (spic_mode_t'(csr_nxt[SPIC_MODE_HI:SPIC_MODE_LO]) != SPIC_MODE_3WIRE); // [RL6]
    case (spic_mode_t'(csr_nxt[SPIC_MODE_HI:SPIC_MODE_LO]))
      SPIC_MODE_OUT0, SPIC_MODE_OUT1: begin
        ss_out_nxt  = csr_nxt[SPIC_MODE_LO];                            // [RL6]
        ss_oe_b_nxt = 1'b0;                                             // [RL6]
      end
      default: begin
        ss_out_nxt  = SPIC_NSS_OUT_RESET;                               // [RL6]
        ss_oe_b_nxt = SPIC_NSS_OEB_RESET;
      end
    endcase
    if (!i_rst_b) begin
      rdata_nxt   = SPIC_RDATA_IDLE;
      irq_nxt     = 1'b0;
      ss_out_nxt  = SPIC_NSS_OUT_RESET;
      ss_oe_b_nxt = SPIC_NSS_OEB_RESET;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    csr_r     <= csr_nxt;
    rdata_r   <= rdata_nxt;
    irq_r     <= irq_nxt;
    ss_out_r  <= ss_out_nxt;
    ss_oe_b_r <= ss_oe_b_nxt;
    ss_used_r <= ss_used_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_sfr_rdata   = rdata_r;
  assign o_spi_irq     = irq_r;
  assign o_ss_out      = ss_out_r;
  assign o_ss_oe_b     = ss_oe_b_r;
  assign o_port_en     = csr_r[SPIC_EN_BIT];
  assign o_select_mode = csr_r[SPIC_MODE_HI:SPIC_MODE_LO];
  assign o_tx_empty    = csr_r[SPIC_TRANSMIT_BUFFER_EMPTY_BIT];
  assign o_ss_used     = ss_used_r;                                     // [RL6]

endmodule // spic_ctrl_status

// ---- common/spic_pkg.sv ----
// Constants and types for the SPI control and status register block
// Notes on behaviour
// RL1: Transfer done sets done flag; software clears.
// RL2: Done flag raises the SPI interrupt request.
// RL3: Data write during transfer sets collision flag.
// RL4: Select low, master, mode 01 sets fault.
// RL5: Slave overrun on last bit with unread data.
// RL6: Mode field: 00 unused, 01 input, 1x output.
// RL7: Buffer-empty cleared on write, set on load.
// RL8: Interrupt request while any flag is set.
package spic_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  SPIC_CSR_ADDR   = 8'hf8;
  localparam logic [7:0]  SPIC_CSR_RESET  = 8'h06;
  localparam logic [7:0]  SPIC_RDATA_IDLE = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SPIC_DONE_BIT   = 7;
  localparam int unsigned SPIC_WRITE_COLLISION_FLAG_BIT   = 6;
  localparam int unsigned SPIC_MODE_FAULT_FLAG_BIT   = 5;
  localparam int unsigned SPIC_OVR_BIT    = 4;
  localparam int unsigned SPIC_MODE_HI    = 3;
  localparam int unsigned SPIC_MODE_LO    = 2;
  localparam int unsigned SPIC_TRANSMIT_BUFFER_EMPTY_BIT  = 1;
  localparam int unsigned SPIC_EN_BIT     = 0;

  // Reset values of the pin-facing outputs and the synchronisers
  localparam logic        SPIC_NSS_OUT_RESET  = 1'b0;
  localparam logic        SPIC_NSS_OEB_RESET  = 1'b1;
  localparam logic        SPIC_SYNC_RESET     = 1'b0;
  localparam logic        SPIC_NSS_SYNC_RESET = 1'b1;

  // ****************************************************************
  // Select modes
  // ****************************************************************
  typedef enum logic [1:0] {
    SPIC_MODE_3WIRE = 2'b00,
    SPIC_MODE_MULTI = 2'b01,
    SPIC_MODE_OUT0  = 2'b10,
    SPIC_MODE_OUT1  = 2'b11
  } spic_mode_t;

endpackage

// ---- common/spic_evt_if.sv ----
// Event crossing signals from the link domain to the register domain
`timescale 1ns/1ps
interface spic_evt_if;
  logic done_tgl;   // Toggles once per finished transfer
  logic load_tgl;   // Toggles when transmit buffer enters shift register
  logic last_tgl;   // Toggles when last bit enters shift register
  logic busy;       // Level, transfer in progress

  modport link (output done_tgl, load_tgl, last_tgl, busy);
  modport core (input  done_tgl, load_tgl, last_tgl, busy);
endinterface

// ---- core/spic_link_evt.sv ----
// Link clock side: turns shift engine pulses into toggles
`timescale 1ns/1ps
module spic_link_evt
  import spic_pkg::*;
(
  input  wire logic i_link_clk,      // Link clock
  input  wire logic i_rst_b,         // System reset, active low
  input  wire logic i_lk_xfer_done,  // Pulse, transfer finished
  input  wire logic i_lk_shift_load, // Pulse, buffer moved to shift register
  input  wire logic i_lk_last_bit,   // Pulse, last bit shifted in
  input  wire logic i_lk_busy,       // Level, transfer in progress
  spic_evt_if.link  evt              // Crossing signals
);

  // ****************************************************************
  // Reset brought into the link domain
  // ****************************************************************
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge i_link_clk) begin
    rst_meta_r <= i_rst_b;
    rst_sync_r <= rst_meta_r;
  end

  // ****************************************************************
  // Event toggles
  // ****************************************************************
  logic done_tgl_r;
  logic done_tgl_nxt;
  logic load_tgl_r;
  logic load_tgl_nxt;
  logic last_tgl_r;
  logic last_tgl_nxt;
  logic busy_r;
  logic busy_nxt;

  always_comb begin
    done_tgl_nxt = done_tgl_r ^ i_lk_xfer_done;
    load_tgl_nxt = load_tgl_r ^ i_lk_shift_load;
    last_tgl_nxt = last_tgl_r ^ i_lk_last_bit;
    busy_nxt     = i_lk_busy;
    if (!rst_sync_r) begin
      done_tgl_nxt = SPIC_SYNC_RESET;
      load_tgl_nxt = SPIC_SYNC_RESET;
      last_tgl_nxt = SPIC_SYNC_RESET;
      busy_nxt     = SPIC_SYNC_RESET;
    end
  end

  always_ff @(posedge i_link_clk) begin
    done_tgl_r <= done_tgl_nxt;
    load_tgl_r <= load_tgl_nxt;
    last_tgl_r <= last_tgl_nxt;
    busy_r     <= busy_nxt;
  end

  assign evt.done_tgl = done_tgl_r;
  assign evt.load_tgl = load_tgl_r;
  assign evt.last_tgl = last_tgl_r;
  assign evt.busy     = busy_r;

endmodule // spic_link_evt

// ---- dv/spic_far_model.sv ----
// Far-side shift engine model driving link-domain event pulses
`timescale 1ns/1ps
module spic_far_model (
  input  wire logic i_link_clk,   // Link clock
  output logic      o_xfer_done,  // Transfer finished
  output logic      o_shift_load, // Buffer into shift register
  output logic      o_last_bit,   // Last bit shifted in
  output logic      o_busy        // Transfer running
);
  initial {o_xfer_done, o_shift_load, o_last_bit, o_busy} = 4'h0;
  // One whole frame; kinds spaced at least 1 link cycle apart
  task automatic run_xfer();
    @(posedge i_link_clk);
    o_busy       <= 1'b1;
    o_shift_load <= 1'b1;
    @(posedge i_link_clk);
    o_shift_load <= 1'b0;
    repeat (4) @(posedge i_link_clk);
    o_last_bit   <= 1'b1;
    @(posedge i_link_clk);
    o_last_bit   <= 1'b0;
    o_xfer_done  <= 1'b1;
    @(posedge i_link_clk);
    o_xfer_done  <= 1'b0;
    o_busy       <= 1'b0;
  endtask
endmodule // spic_far_model

// ---- dv/spic_ctrl_status_asserts.sv ----
// Port-level checks for the SPI control and status block
`timescale 1ns/1ps
module spic_ctrl_status_asserts
  import spic_pkg::*;
(
  input wire logic       i_sys_clk,       // Clock
  input wire logic       i_rst_b,         // Reset
  input wire logic [7:0] i_sfr_addr,      // Address
  input wire logic       i_sfr_wr,        // Write
  input wire logic       i_sfr_rd,        // Read
  input wire logic [7:0] i_sfr_wdata,     // Write data
  input wire logic [7:0] o_sfr_rdata,     // Read data
  input wire logic       i_data_reg_wr,   // Data write
  input wire logic       i_rx_buf_full,   // Rx full
  input wire logic       i_master_en,     // Master
  input wire logic       i_link_clk,      // Link clock
  input wire logic       i_lk_xfer_done,  // Done pulse
  input wire logic       i_lk_shift_load, // Load pulse
  input wire logic       i_lk_last_bit,   // Last bit
  input wire logic       i_lk_busy,       // Busy
  input wire logic       i_ss_in,         // Select in
  input wire logic       o_ss_out,        // Select out
  input wire logic       o_ss_oe_b,       // Select enable
  input wire logic       o_spi_irq,       // Interrupt
  input wire logic       o_port_en,       // Enable
  input wire logic [1:0] o_select_mode,   // Mode
  input wire logic       o_tx_empty,      // Tx empty
  input wire logic       o_ss_used        // Select used
);
  // ****************************************************************
  // Port checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire rd_hit = i_sfr_rd && (i_sfr_addr == SPIC_CSR_ADDR);
  wire wr_hit = i_sfr_wr && (i_sfr_addr == SPIC_CSR_ADDR);
  a_read_idle: assert property (!$past(rd_hit) |-> o_sfr_rdata == 8'h00) else $error("rdata not idle");
  a_read_flags: assert property ($past(rd_hit) |-> (|o_sfr_rdata[7:4]) == $past(o_spi_irq))
    else $error("flags and irq disagree");
  a_read_fields: assert property ($past(rd_hit) |-> o_sfr_rdata[3:0] ==
    {$past(o_select_mode), $past(o_tx_empty), $past(o_port_en)}) else $error("field readback");
  a_write_fields: assert property (wr_hit |=> o_port_en == $past(i_sfr_wdata[0])
    && o_select_mode == $past(i_sfr_wdata[3:2])) else $error("write not taken");
  a_irq_hold: assert property (o_spi_irq && !wr_hit |=> o_spi_irq) else $error("irq dropped");
  a_txe_clear: assert property (i_data_reg_wr |=> !o_tx_empty) else $error("tx empty stays");
  a_ss_drive: assert property (o_select_mode[1] && $stable(o_select_mode) |->
    !o_ss_oe_b && o_ss_out == o_select_mode[0]) else $error("select not driven");
  a_ss_release: assert property (!o_select_mode[1] && $stable(o_select_mode) |-> o_ss_oe_b)
    else $error("select driven");
  a_ss_route: assert property (o_ss_used == (o_select_mode != 2'b00)) else $error("select routing");
  a_mode_fault: assert property ((!i_ss_in && i_master_en && o_select_mode == 2'b01) [*6] |-> o_spi_irq)
    else $error("mode fault missed");
  c_irq: cover property ($rose(o_spi_irq));
  c_drive: cover property (!o_ss_oe_b);
  c_read: cover property (rd_hit ##1 o_sfr_rdata[7]);
endmodule // spic_ctrl_status_asserts

bind spic_ctrl_status spic_ctrl_status_asserts chk_u (.*);

// ---- dv/testbench.sv ----
// Self-checking bench for the SPI control and status block
`timescale 1ns/1ps
module testbench;
  import spic_pkg::*;
  logic       i_sys_clk = 1'b0, i_link_clk = 1'b0, i_rst_b = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
  logic       i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_data_reg_wr = 1'b0;
  logic       i_rx_buf_full = 1'b0, i_master_en = 1'b0, i_ss_in = 1'b1;
  logic       i_lk_xfer_done, i_lk_shift_load, i_lk_last_bit, i_lk_busy;
  logic       o_ss_out, o_ss_oe_b, o_spi_irq, o_port_en, o_tx_empty, o_ss_used;
  logic [1:0] o_select_mode;
  int         n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  initial begin
    #17.3;
    forever #62.5 i_link_clk = ~i_link_clk;
  end
  spic_ctrl_status dut_u (.*);
  spic_far_model far_u (.i_link_clk(i_link_clk), .o_xfer_done(i_lk_xfer_done),
    .o_shift_load(i_lk_shift_load), .o_last_bit(i_lk_last_bit), .o_busy(i_lk_busy));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_sys_clk);
    i_sfr_wr = 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_sys_clk);
    i_sfr_rd = 1'b0;
    cmp_count++;
    if (o_sfr_rdata !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t read %h got %h exp %h", $time, a, o_sfr_rdata, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t pin %s got %b", $time, what, got);
    end
  endtask
  task automatic data_wr();
    @(negedge i_sys_clk);
    i_data_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_data_reg_wr = 1'b0;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [1:0] m;
    idle(12);
    i_rst_b = 1'b1;
    idle(75); // Link domain leaves reset meanwhile
    chk_rd(8'hf8, 8'h06);
    chk_rd(8'hf7, 8'h00);
    bus_wr(8'hf8, 8'hff);
    chk_rd(8'hf8, 8'hff);
    bus_wr(8'hf8, 8'h05);
    chk_rd(8'hf8, 8'h07);
    chk_pin(o_spi_irq, 1'b0, "irq");
    for (int i = 2; i < 6; i++) begin
      m = i[1:0];
      bus_wr(8'hf8, {4'h0, m, 2'b01});
      idle(2);
      chk_pin(o_ss_oe_b, !m[1], "oe");
      if (m[1]) chk_pin(o_ss_out, m[0], "out");
      chk_pin(o_ss_used, m != 2'b00, "used");
      chk_pin(o_select_mode[1], m[1], "mode");
      chk_pin(o_port_en, 1'b1, "en");
    end
    i_master_en = 1'b1;
    data_wr();
    chk_pin(o_tx_empty, 1'b0, "txe");
    far_u.run_xfer();
    idle(8);
    chk_rd(8'hf8, 8'h87);
    chk_pin(o_spi_irq, 1'b1, "irq");
    idle(50);
    chk_rd(8'hf8, 8'h87);
    bus_wr(8'hf8, 8'h05);
    chk_rd(8'hf8, 8'h07);
    fork
      far_u.run_xfer();
      begin
        repeat (3) @(posedge i_link_clk);
        data_wr();
      end
    join
    idle(8);
    chk_rd(8'hf8, 8'hc5);
    bus_wr(8'hf8, 8'h05);
    i_master_en = 1'b0;
    i_rx_buf_full = 1'b1;
    far_u.run_xfer();
    idle(8);
    chk_rd(8'hf8, 8'h97);
    bus_wr(8'hf8, 8'h05);
    i_rx_buf_full = 1'b0;
    i_master_en = 1'b1;
    @(negedge i_sys_clk);
    i_ss_in = 1'b0;
    idle(8);
    i_ss_in = 1'b1;
    idle(4);
    chk_rd(8'hf8, 8'h27);
    bus_wr(8'hf8, 8'h05);
    bus_wr(8'hf7, 8'h00);
    chk_rd(8'hf8, 8'h07);
    tally_and_finish();
  end
endmodule // testbench
